/* File: core/ppu_pkg.sv */
`default_nettype none
package ppu_pkg;
  // Pixel modes held in the control register
  typedef enum logic [1:0] {
    PPU_IDX8 = 2'b00,
    PPU_RGB555 = 2'b01,
    PPU_RGB565 = 2'b10,
    PPU_RGB32 = 2'b11
  } ppu_mode_t;
  // Cursor bitmap fetch sequencer
  typedef enum logic {
    PPU_F_IDLE = 1'b0,
    PPU_F_FETCH = 1'b1
  } ppu_fetch_t;
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CUR_BASE = 12'h004;
  localparam logic [11:0] ADDR_CUR_POS = 12'h008;
  localparam logic [11:0] ADDR_LUT_IDX = 12'h00c;
  localparam logic [11:0] ADDR_LUT_DATA = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_SER_CTRL = 12'h018;
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEL_BIT = 2;
  localparam int CTRL_CUR_BIT = 3;
  localparam int POS_Y_LSB = 16;
  localparam int SER_STRETCH_BIT = 0;
  localparam int SER_RELEASE_BIT = 1;
  localparam int STAT_PWR_BIT = 0;
  localparam int STAT_FETCH_BIT = 1;
  localparam int STAT_LOADED_BIT = 2;
  localparam int STAT_HOLD_BIT = 3;
  // Sizes
  localparam int LUT_DEPTH = 256;
  localparam int CUR_DIM = 32;
  localparam int CUR_WORDS = 512;
  localparam logic [8:0] CUR_LAST_WORD = 9'h1ff;
  localparam logic [15:0] CUR_INVERT = 16'h7fff;
  // 10-bit colour carrier towards the DACs
  typedef struct packed {
    logic [9:0] r;
    logic [9:0] g;
    logic [9:0] b;
  } ppu_rgb_t;
  // One decoded pixel: route, table indices and bypass colour
  typedef struct packed {
    logic use_lut;
    logic [7:0] ir;
    logic [7:0] ig;
    logic [7:0] ib;
    ppu_rgb_t byp;
  } ppu_dec_t;
endpackage
`default_nettype wire

/* File: core/ppu_lut.sv */
`timescale 1ns/10ps
`default_nettype none
// Colour table with one write port and three registered read ports
module ppu_lut (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [23:0] wdata,
  // Read ports, one per colour channel
  input wire logic re,
  input wire logic [7:0] ra_r,
  input wire logic [7:0] ra_g,
  input wire logic [7:0] ra_b,
  output logic [23:0] q_r,
  output logic [23:0] q_g,
  output logic [23:0] q_b
);
  typedef struct packed {
    logic [23:0] r;
    logic [23:0] g;
    logic [23:0] b;
  } ppu_lut_st_t;
  logic [23:0] mem [ppu_pkg::LUT_DEPTH];
  ppu_lut_st_t st_ff, nxt_st;
  // Reads stay frozen while powered down so the array does not toggle
  always_comb begin
    nxt_st = st_ff;
    if (re) begin
      nxt_st.r = mem[ra_r];
      nxt_st.g = mem[ra_g];
      nxt_st.b = mem[ra_b];
    end
  end
  // Table storage
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  // Read registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q_r = st_ff.r;
  assign q_g = st_ff.g;
  assign q_b = st_ff.b;
endmodule // ppu_lut
`default_nettype wire

/* File: core/ppu_cursor_ram.sv */
`timescale 1ns/10ps
`default_nettype none
// Cursor pattern store: 512 words of two 16-bit cursor pixels
module ppu_cursor_ram (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill port from the bitmap fetch
  input wire logic we,
  input wire logic [8:0] waddr,
  input wire logic [31:0] wdata,
  // Pixel read port, index is row * 32 + column
  input wire logic [9:0] raddr,
  output logic [15:0] q
);
  typedef struct packed {
    logic [15:0] q;
  } ppu_cram_st_t;
  logic [31:0] mem [ppu_pkg::CUR_WORDS];
  ppu_cram_st_t st_ff, nxt_st;
  // Even pixel sits in the low half, as in the framebuffer
  always_comb begin
    nxt_st = st_ff;
    nxt_st.q = raddr[0] ? mem[raddr[9:1]][31:16] : mem[raddr[9:1]][15:0];
  end
  // Pattern storage
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  // Read register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q = st_ff.q;
endmodule // ppu_cursor_ram
`default_nettype wire

/* File: core/ppu_top.sv */
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
//- Indexed mode: four byte pixels per word, pixel 0 in lowest byte.
//- Colour table holds 256 entries of 24 bits, indexed by pixel.
//- 5:5:5 with selection on: pixel top bit picks bypass or table.
//- 5:5:5 with selection off: always bypass, table powered down.
//- 5:6:5 always bypasses the table.
//- 32-bit: bit 31 picks bypass or table.
//- 32-bit bypass: 10-bit colours, low two bits from top byte.
//- Wide buses carry several pixel words, lowest word first.
//- Cursor is 32 by 32 pixels of 15-bit colour.
//- Cursor pattern fetched from a 2 KB bitmap at programmed address.
//- Cursor pixel: replace flag on top, then 5-bit red, green, blue.
//- Cursor colours widen to 10 bits by repeating the five bits.
//- Replace flag set replaces pixel, clear XORs widened colour in.
//- Cursor pixel zero leaves display pixel untouched.
//- Cursor pixel 7fff with flag clear inverts every display bit.
//- Cursor merge is the last stage, over any video window.
//- Serial clock held low on incoming messages until software frees it.
module ppu_top #(
  parameter int BUS_W = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Framebuffer pixel words
  input wire logic fb_valid,
  input wire logic [BUS_W-1:0] frame_data_bus,
  output logic fb_ready,
  // Raster timing pulses
  input wire logic line_start,
  input wire logic frame_start,
  // Cursor bitmap fetch
  output logic cur_req,
  output logic [23:0] cur_addr,
  input wire logic cur_rvalid,
  input wire logic [31:0] cur_rdata,
  // Pixels towards the DACs
  output logic pix_valid,
  output ppu_pkg::ppu_rgb_t pix_rgb,
  output logic lut_pwr_dn,
  // Serial clock pin, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n
);
  localparam int WORDS = BUS_W / 32;
  localparam int WSEL_W = (WORDS > 1) ? $clog2(WORDS) : 1;
  localparam logic [WSEL_W-1:0] WSEL_LAST = WSEL_W'(WORDS - 1);

  typedef struct packed {
    ppu_pkg::ppu_mode_t mode;
    logic sel_en;
    logic cur_en;
    logic [23:0] cur_base;
    logic [11:0] cur_x;
    logic [11:0] cur_y;
    logic [7:0] lut_idx;
    logic stretch_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic busy;
    logic fb_ready;
    logic [BUS_W-1:0] wbuf;
    logic [WSEL_W-1:0] wsel;
    logic [1:0] pix;
    logic [11:0] x;
    logic [11:0] y;
    logic a_valid;
    logic a_use_lut;
    logic a_hit;
    ppu_pkg::ppu_rgb_t a_byp;
    logic [7:0] a_ir;
    ppu_pkg::ppu_fetch_t fst;
    logic [8:0] fcnt;
    logic loaded;
    logic cur_req;
    logic [23:0] cur_addr;
    logic o_valid;
    ppu_pkg::ppu_rgb_t o_rgb;
    logic pwr_dn;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic pending;
    logic scl_oe_n;
  } ppu_state_t;

  ppu_state_t st_ff, nxt_st;
  ppu_pkg::ppu_dec_t dec;
  ppu_pkg::ppu_rgb_t base, cexp;
  logic [23:0] lq_r, lq_g, lq_b;
  logic [15:0] cur_q;
  logic [9:0] cram_ra;
  logic [11:0] dx, dy;
  logic lut_we, apb_wr, last_pix, fall, hit, pwr_cond;
  logic [31:0] cur_word;

  // Split one 32-bit pixel word into the selected pixel's route and colour
  function automatic ppu_pkg::ppu_dec_t ppu_decode(input ppu_pkg::ppu_mode_t mode,
      input logic sel_en, input logic [31:0] w, input logic [1:0] pix);
    ppu_pkg::ppu_dec_t d;
    logic [15:0] h;
    logic [7:0] b8;
    d = '0;
    h = pix[0] ? w[31:16] : w[15:0];
    b8 = w[8*pix +: 8];
    case (mode)
      ppu_pkg::PPU_IDX8: begin
        d.use_lut = 1'b1;
        d.ir = b8;
        d.ig = b8;
        d.ib = b8;
      end
      ppu_pkg::PPU_RGB555: begin
        d.use_lut = sel_en & ~h[15];
        d.ir = {h[14:10], h[14:12]};
        d.ig = {h[9:5], h[9:7]};
        d.ib = {h[4:0], h[4:2]};
        d.byp = {h[14:10], h[14:10], h[9:5], h[9:5], h[4:0], h[4:0]};
      end
      ppu_pkg::PPU_RGB565: begin
        d.use_lut = 1'b0;
        d.byp = {h[15:11], h[15:11], h[10:5], h[10:7], h[4:0], h[4:0]};
      end
      default: begin
        d.use_lut = ~w[31];
        d.ir = w[23:16];
        d.ig = w[15:8];
        d.ib = w[7:0];
        d.byp = {w[23:16], w[29:28], w[15:8], w[27:26], w[7:0], w[25:24]};
      end
    endcase
    return d;
  endfunction

  // Colour table; reads are frozen while the 5:5:5 bypass-only mode powers it down
  ppu_lut u_lut (
    .pclk(pclk),
    .presetn(presetn),
    .we(lut_we),
    .waddr(st_ff.lut_idx),
    .wdata(pwdata[23:0]),
    .re(~st_ff.pwr_dn),
    .ra_r(dec.ir),
    .ra_g(dec.ig),
    .ra_b(dec.ib),
    .q_r(lq_r),
    .q_g(lq_g),
    .q_b(lq_b)
  );

  // Cursor pattern store, filled by the flyback fetch
  ppu_cursor_ram u_cram (
    .pclk(pclk),
    .presetn(presetn),
    .we(st_ff.cur_req & cur_rvalid),
    .waddr(st_ff.fcnt),
    .wdata(cur_rdata),
    .raddr(cram_ra),
    .q(cur_q)
  );

  // Per-pixel helpers: current word, cursor window, merge inputs
  assign cur_word = st_ff.wbuf[32*int'(st_ff.wsel) +: 32];
  assign dx = st_ff.x - st_ff.cur_x;
  assign dy = st_ff.y - st_ff.cur_y;
  assign hit = st_ff.cur_en & st_ff.loaded & (dx[11:5] == 7'h00) & (dy[11:5] == 7'h00);
  assign cram_ra = {dy[4:0], dx[4:0]};
  assign base = st_ff.a_use_lut ?
      {lq_r[23:16], lq_r[23:22], lq_g[15:8], lq_g[15:14], lq_b[7:0], lq_b[7:6]} : st_ff.a_byp;
  assign cexp = {cur_q[14:10], cur_q[14:10], cur_q[9:5], cur_q[9:5], cur_q[4:0], cur_q[4:0]};
  assign apb_wr = psel & penable & st_ff.pready & pwrite;
  assign lut_we = apb_wr & (paddr == ppu_pkg::ADDR_LUT_DATA);
  assign fall = st_ff.scl_s3 & ~st_ff.scl_s2;
  assign pwr_cond = (st_ff.mode == ppu_pkg::PPU_RGB555) & ~st_ff.sel_en;
  assign last_pix = (st_ff.mode == ppu_pkg::PPU_IDX8) ? (st_ff.pix == 2'd3) :
      (st_ff.mode == ppu_pkg::PPU_RGB32) ? 1'b1 : (st_ff.pix == 2'd1);

  // Next-state logic for registers, unpacker, cursor fetch and serial hold
  always_comb begin
    nxt_st = st_ff;
    dec = ppu_decode(st_ff.mode, st_ff.sel_en, cur_word, st_ff.pix);
    // APB: zero-wait answer, data and error prepared in the setup cycle
    nxt_st.pready = psel & ~penable;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata = '0;
    if (psel & ~penable) begin
      if (paddr == ppu_pkg::ADDR_CTRL) begin
        nxt_st.prdata = {28'h0000000, st_ff.cur_en, st_ff.sel_en, st_ff.mode};
      end else if (paddr == ppu_pkg::ADDR_CUR_BASE) begin
        nxt_st.prdata = {8'h00, st_ff.cur_base};
      end else if (paddr == ppu_pkg::ADDR_CUR_POS) begin
        nxt_st.prdata = {4'h0, st_ff.cur_y, 4'h0, st_ff.cur_x};
      end else if (paddr == ppu_pkg::ADDR_LUT_IDX) begin
        nxt_st.prdata = {24'h000000, st_ff.lut_idx};
      end else if (paddr == ppu_pkg::ADDR_LUT_DATA) begin
        nxt_st.prdata = '0; // Write only
      end else if (paddr == ppu_pkg::ADDR_STATUS) begin
        nxt_st.prdata[ppu_pkg::STAT_PWR_BIT] = st_ff.pwr_dn;
        nxt_st.prdata[ppu_pkg::STAT_FETCH_BIT] = st_ff.fst == ppu_pkg::PPU_F_FETCH;
        nxt_st.prdata[ppu_pkg::STAT_LOADED_BIT] = st_ff.loaded;
        nxt_st.prdata[ppu_pkg::STAT_HOLD_BIT] = st_ff.pending;
      end else if (paddr == ppu_pkg::ADDR_SER_CTRL) begin
        nxt_st.prdata[ppu_pkg::SER_STRETCH_BIT] = st_ff.stretch_en;
      end else begin
        nxt_st.pslverr = 1'b1;
      end
    end
    if (apb_wr) begin
      if (paddr == ppu_pkg::ADDR_CTRL) begin
        nxt_st.mode = ppu_pkg::ppu_mode_t'(pwdata[ppu_pkg::CTRL_MODE_LSB +: 2]);
        nxt_st.sel_en = pwdata[ppu_pkg::CTRL_SEL_BIT];
        nxt_st.cur_en = pwdata[ppu_pkg::CTRL_CUR_BIT];
      end else if (paddr == ppu_pkg::ADDR_CUR_BASE) begin
        nxt_st.cur_base = pwdata[23:0];
      end else if (paddr == ppu_pkg::ADDR_CUR_POS) begin
        nxt_st.cur_x = pwdata[11:0];
        nxt_st.cur_y = pwdata[ppu_pkg::POS_Y_LSB +: 12];
      end else if (paddr == ppu_pkg::ADDR_LUT_IDX) begin
        nxt_st.lut_idx = pwdata[7:0];
      end else if (paddr == ppu_pkg::ADDR_LUT_DATA) begin
        nxt_st.lut_idx = st_ff.lut_idx + 8'h01; // Auto-step for bulk loads
      end else if (paddr == ppu_pkg::ADDR_SER_CTRL) begin
        nxt_st.stretch_en = pwdata[ppu_pkg::SER_STRETCH_BIT];
      end
    end
    nxt_st.pwr_dn = pwr_cond;
    // Unpacker: take a bus word, emit one pixel per cycle, lowest word first
    nxt_st.a_valid = st_ff.busy;
    nxt_st.a_use_lut = dec.use_lut;
    nxt_st.a_byp = dec.byp;
    nxt_st.a_ir = dec.ir;
    nxt_st.a_hit = hit;
    if (st_ff.busy) begin
      nxt_st.x = st_ff.x + 12'h001;
      if (last_pix) begin
        nxt_st.pix = 2'd0;
        if (st_ff.wsel == WSEL_LAST) begin
          nxt_st.busy = 1'b0;
        end else begin
          nxt_st.wsel = st_ff.wsel + 1'b1;
        end
      end else begin
        nxt_st.pix = st_ff.pix + 2'd1;
      end
    end else if (fb_valid & st_ff.fb_ready) begin
      nxt_st.busy = 1'b1;
      nxt_st.wbuf = frame_data_bus;
      nxt_st.wsel = '0;
      nxt_st.pix = 2'd0;
    end
    nxt_st.fb_ready = ~nxt_st.busy;
    // Raster position, frame start wins over line start
    if (frame_start) begin
      nxt_st.x = 12'h000;
      nxt_st.y = 12'h000;
    end else if (line_start) begin
      nxt_st.x = 12'h000;
      if (st_ff.x != 12'h000) begin
        nxt_st.y = st_ff.y + 12'h001;
      end
    end
    // Final stage: cursor over the finished display pixel
    nxt_st.o_valid = st_ff.a_valid;
    nxt_st.o_rgb = base;
    if (st_ff.a_hit & (cur_q != 16'h0000)) begin
      nxt_st.o_rgb = cur_q[15] ? cexp : (base ^ cexp);
    end
    // Cursor bitmap fetch, started at flyback so the pattern never tears
    case (st_ff.fst)
      ppu_pkg::PPU_F_IDLE: begin
        if (frame_start & st_ff.cur_en) begin
          nxt_st.fst = ppu_pkg::PPU_F_FETCH;
          nxt_st.cur_req = 1'b1;
          nxt_st.cur_addr = st_ff.cur_base;
          nxt_st.fcnt = 9'h000;
          nxt_st.loaded = 1'b0;
        end
      end
      ppu_pkg::PPU_F_FETCH: begin
        if (cur_rvalid) begin
          nxt_st.fcnt = st_ff.fcnt + 9'h001;
          nxt_st.cur_addr = st_ff.cur_addr + 24'h000001;
          if (st_ff.fcnt == ppu_pkg::CUR_LAST_WORD) begin
            nxt_st.fst = ppu_pkg::PPU_F_IDLE;
            nxt_st.cur_req = 1'b0;
            nxt_st.loaded = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.fst = ppu_pkg::PPU_F_IDLE;
      end
    endcase
    // Serial clock: hold low after a falling edge; a new edge beats the release
    nxt_st.scl_s1 = scl_i;
    nxt_st.scl_s2 = st_ff.scl_s1;
    nxt_st.scl_s3 = st_ff.scl_s2;
    nxt_st.pending = (fall & st_ff.stretch_en) |
        (st_ff.pending & ~(apb_wr & (paddr == ppu_pkg::ADDR_SER_CTRL) &
        pwdata[ppu_pkg::SER_RELEASE_BIT]));
    nxt_st.scl_oe_n = ~nxt_st.pending;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.scl_oe_n <= 1'b1;
      st_ff.scl_s1 <= 1'b1;
      st_ff.scl_s2 <= 1'b1;
      st_ff.scl_s3 <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register, except scl_o which is tied low
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign fb_ready = st_ff.fb_ready;
  assign cur_req = st_ff.cur_req;
  assign cur_addr = st_ff.cur_addr;
  assign pix_valid = st_ff.o_valid;
  assign pix_rgb = st_ff.o_rgb;
  assign lut_pwr_dn = st_ff.pwr_dn;
  assign scl_o = 1'b0;
  assign scl_oe_n = st_ff.scl_oe_n;

  // Checks on the pixel path, the cursor fetch start and the serial clock hold
  property p_idx_byte0;
    @(posedge pclk) disable iff (!presetn)
    (st_ff.busy && st_ff.mode == ppu_pkg::PPU_IDX8 && st_ff.pix == 2'd0 && st_ff.wsel == '0)
      |=> (st_ff.a_ir == $past(st_ff.wbuf[7:0]) && st_ff.a_use_lut);
  endproperty
  a_idx_byte0: assert property (p_idx_byte0) else $error("index pixel 0 not low byte");
  property p_pwr_dn;
    @(posedge pclk) disable iff (!presetn)
    pwr_cond |=> lut_pwr_dn;
  endproperty
  a_pwr_dn: assert property (p_pwr_dn) else $error("table not powered down");
  property p_565_bypass;
    @(posedge pclk) disable iff (!presetn)
    (st_ff.busy && st_ff.mode == ppu_pkg::PPU_RGB565) |=> !st_ff.a_use_lut;
  endproperty
  a_565_bypass: assert property (p_565_bypass) else $error("5:6:5 pixel used table");
  property p_transparent;
    @(posedge pclk) disable iff (!presetn)
    (st_ff.a_valid && st_ff.a_hit && cur_q == 16'h0000) |=> (pix_rgb == $past(base));
  endproperty
  a_transparent: assert property (p_transparent) else $error("transparent cursor changed pixel");
  property p_replace;
    @(posedge pclk) disable iff (!presetn)
    (st_ff.a_valid && st_ff.a_hit && cur_q[15]) |=> (pix_rgb == $past(cexp) && pix_valid);
  endproperty
  a_replace: assert property (p_replace) else $error("replace cursor not shown");
  property p_invert;
    @(posedge pclk) disable iff (!presetn)
    (st_ff.a_valid && st_ff.a_hit && cur_q == ppu_pkg::CUR_INVERT) |=> (pix_rgb == ~$past(base));
  endproperty
  a_invert: assert property (p_invert) else $error("invert cursor failed");
  property p_fetch_start;
    @(posedge pclk) disable iff (!presetn)
    (frame_start && st_ff.cur_en && st_ff.fst == ppu_pkg::PPU_F_IDLE)
      |=> (cur_req && cur_addr == $past(st_ff.cur_base));
  endproperty
  a_fetch_start: assert property (p_fetch_start) else $error("cursor fetch did not start");
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (fall && st_ff.stretch_en) |=> !scl_oe_n ##1 (!scl_oe_n || $past(apb_wr));
  endproperty
  a_hold: assert property (p_hold) else $error("serial clock not held");
endmodule // ppu_top
`default_nettype wire

/* File: dv/ppu_fb_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Off-screen memory answering the cursor bitmap fetch, at full or slowed pace
module ppu_fb_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fetch request and the pattern held in memory
  input wire logic cur_req,
  input wire logic [15:0] pat,
  input wire logic slow,
  // Read answer
  output logic cur_rvalid,
  output logic [31:0] cur_rdata
);
  logic [1:0] gap_ff;
  // One word per answer, a gap after each so the address can step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_rvalid <= 1'b0;
      gap_ff <= 2'h0;
    end else if (cur_rvalid) begin
      cur_rvalid <= 1'b0;
      gap_ff <= slow ? 2'h2 : 2'h0;
    end else if (gap_ff != 2'h0) begin
      gap_ff <= gap_ff - 2'h1;
    end else begin
      cur_rvalid <= cur_req;
    end
  end
  // Outside an answer the data is inverted so stale words cannot pass
  assign cur_rdata = cur_rvalid ? {pat, pat} : ~{pat, pat};
endmodule // ppu_fb_model
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [1:0] m; logic s; logic pd; logic [31:0] w;} ppu_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] frame_data_bus = 32'h0;
  logic fb_valid = 1'b0;
  logic line_start = 1'b0;
  logic frame_start = 1'b0;
  logic scl_ext = 1'b1;
  logic slow = 1'b0;
  logic [15:0] pat = 16'h0;
  logic [31:0] prdata, cur_rdata, q;
  logic pready, pslverr, fb_ready, cur_req, cur_rvalid, pix_valid, lut_pwr_dn, scl_o, scl_oe_n;
  logic e;
  logic [23:0] cur_addr;
  ppu_pkg::ppu_rgb_t pix_rgb, p;
  ppu_row_t rows [6];
  logic [15:0] cp [3];
  int errors = 0;
  int n_checks = 0;
  wire logic scl_i;
  // Open-drain wire: low if either side pulls
  assign scl_i = scl_ext & (scl_oe_n | scl_o);
  always #50 pclk = ~pclk;
  ppu_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fb_valid, .frame_data_bus, .fb_ready, .line_start, .frame_start, .cur_req,
    .cur_addr, .cur_rvalid, .cur_rdata, .pix_valid, .pix_rgb, .lut_pwr_dn, .scl_i, .scl_o,
    .scl_oe_n);
  ppu_fb_model i_mem (.pclk, .presetn, .cur_req, .pat, .slow, .cur_rvalid, .cur_rdata);
  // Table contents chosen so every channel differs
  function automatic logic [23:0] tbl(logic [7:0] i);
    return {i, ~i, i ^ 8'h5a};
  endfunction
  function automatic logic [9:0] wd(logic [7:0] v);
    return {v, v[7:6]};
  endfunction
  // Reference pixel k of word w in mode m with select s
  function automatic ppu_pkg::ppu_rgb_t expx(logic [1:0] m, logic s, logic [31:0] w, int k);
    logic [15:0] h;
    logic [23:0] er, eg, eb;
    h = w[16*(k%2) +: 16];
    er = tbl(w[8*k +: 8]);
    if (m == 2'h0) return {wd(er[23:16]), wd(er[15:8]), wd(er[7:0])};
    if (m == 2'h2) return {h[15:11], h[15:11], h[10:5], h[10:7], h[4:0], h[4:0]};
    if (m == 2'h3 && w[31]) return {w[23:16], w[29:28], w[15:8], w[27:26], w[7:0], w[25:24]};
    if (m == 2'h1 && !(s && !h[15])) return {h[14:10], h[14:10], h[9:5], h[9:5], h[4:0], h[4:0]};
    if (m == 2'h3) begin
      er = tbl(w[23:16]);
      eg = tbl(w[15:8]);
      eb = tbl(w[7:0]);
    end else begin
      er = tbl({h[14:10], h[14:12]});
      eg = tbl({h[9:5], h[9:7]});
      eb = tbl({h[4:0], h[4:2]});
    end
    return {wd(er[23:16]), wd(eg[15:8]), wd(eb[7:0])};
  endfunction
  // Cursor merge reference: zero is transparent, top bit replaces, else XOR
  function automatic ppu_pkg::ppu_rgb_t cm(logic [15:0] c, ppu_pkg::ppu_rgb_t b);
    ppu_pkg::ppu_rgb_t x;
    x = {c[14:10], c[14:10], c[9:5], c[9:5], c[4:0], c[4:0]};
    return (c == 16'h0000) ? b : (c[15] ? x : (b ^ x));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 20);
    if (t >= 20) errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One whole framebuffer word, held until taken
  task automatic send(input logic [31:0] w);
    int t;
    t = 0;
    @(posedge pclk);
    fb_valid <= 1'b1;
    frame_data_bus <= w;
    do begin @(posedge pclk); t++; end while (fb_ready !== 1'b1 && t < 30);
    if (t >= 30) errors++;
    fb_valid <= 1'b0;
    frame_data_bus <= ~w;
  endtask
  task automatic getpix;
    int t;
    t = 0;
    do begin @(posedge pclk); t++; end while (pix_valid !== 1'b1 && t < 30);
    if (t >= 30) errors++;
    p = pix_rgb;
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog sized well above the expected run of some 5000 cycles
  initial begin
    #2000000;
    errors++;
    conclude();
  end
  initial begin
    rows[0] = '{2'h0, 1'b0, 1'b0, 32'h80ff0512};
    rows[1] = '{2'h1, 1'b0, 1'b1, 32'h7c1f83e0};
    rows[2] = '{2'h1, 1'b1, 1'b0, 32'h7c1f83e0};
    rows[3] = '{2'h2, 1'b0, 1'b0, 32'hf81f07e0};
    rows[4] = '{2'h3, 1'b0, 1'b0, 32'ha4123456};
    rows[5] = '{2'h3, 1'b0, 1'b0, 32'h7fabcdef};
    cp = '{16'h0000, 16'h7fff, 16'h8a53};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({scl_oe_n, pix_valid, lut_pwr_dn}, 32'h4);
    $display("Reset test done");
    // Whole table loaded through the auto-incrementing index
    apb(1'b1, ppu_pkg::ADDR_LUT_IDX, 32'h0);
    for (int i = 0; i < 256; i++) apb(1'b1, ppu_pkg::ADDR_LUT_DATA, {8'h00, tbl(i[7:0])});
    // Whole words only, so line lengths stay legal
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ppu_pkg::ADDR_CTRL, {29'h0, rows[i].s, rows[i].m});
      send(rows[i].w);
      for (int k = 0; k < ((rows[i].m == 2'h0) ? 4 : (rows[i].m == 2'h3) ? 1 : 2); k++) begin
        getpix();
        chk(p, expx(rows[i].m, rows[i].s, rows[i].w, k));
      end
      chk(lut_pwr_dn, rows[i].pd);
      $display("Row %0d done", i);
    end
    apb(1'b0, 12'h0fc, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    $display("Unmapped access test done");
    // Cursor changed only between frames
    apb(1'b1, ppu_pkg::ADDR_CUR_BASE, 32'h00123450);
    apb(1'b1, ppu_pkg::ADDR_CUR_POS, 32'h0);
    for (int j = 0; j < 3; j++) begin
      int t;
      pat <= cp[j];
      slow <= j[0];
      apb(1'b1, ppu_pkg::ADDR_CTRL, 32'h0000000a);
      @(posedge pclk);
      frame_start <= 1'b1;
      @(posedge pclk);
      frame_start <= 1'b0;
      @(posedge pclk);
      chk({cur_req, cur_addr}, {1'b1, 24'h123450});
      t = 0;
      do begin @(posedge pclk); t++; end while (cur_req === 1'b1 && t < 4000);
      apb(1'b0, ppu_pkg::ADDR_STATUS, 32'h0);
      chk({t < 4000, q[2]}, 32'h3);
      send(32'h07e0f81f);
      for (int k = 0; k < 2; k++) begin
        getpix();
        chk(p, cm(cp[j], expx(2'h2, 1'b0, 32'h07e0f81f, k)));
      end
      $display("Cursor test %0d done", j);
    end
    // Clock stretch: held after a fall, freed by the release write
    apb(1'b1, ppu_pkg::ADDR_SER_CTRL, 32'h1);
    scl_ext <= 1'b0;
    repeat (8) @(posedge pclk);
    scl_ext <= 1'b1;
    apb(1'b0, ppu_pkg::ADDR_STATUS, 32'h0);
    chk({scl_oe_n, scl_i, q[3]}, 32'h1);
    apb(1'b1, ppu_pkg::ADDR_SER_CTRL, 32'h3);
    repeat (8) @(posedge pclk);
    chk({scl_oe_n, scl_i}, 32'h3);
    $display("Serial clock test done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
